// ==== hdl/fcc_pkg.sv ====
// Package for the field current controller: register map, reset values,
// field layouts and loop constants.
// Assumes a 25 MHz system clock and a 32-bit APB register bus.
package fcc_pkg;

   // ==========================================================
   // Register byte addresses
   localparam logic [7:0] OFS_CONFIG       = 8'h00;
   localparam logic [7:0] OFS_STATUS       = 8'h04;
   localparam logic [7:0] OFS_FIELD_DEMAND = 8'h08;
   localparam logic [7:0] OFS_FIELD_FBK    = 8'h0C;
   localparam logic [7:0] OFS_FIRING       = 8'h10;
   localparam logic [7:0] OFS_IR_OUT       = 8'h14;
   localparam logic [7:0] OFS_IR_FACTOR    = 8'h18;
   localparam logic [7:0] OFS_EMF_SET      = 8'h1C;
   localparam logic [7:0] OFS_MAX_PRIMARY  = 8'h20;
   localparam logic [7:0] OFS_MAX_ECONOMY  = 8'h24;
   localparam logic [7:0] OFS_MIN_FIELD    = 8'h28;
   localparam logic [7:0] OFS_FBK_SCALE    = 8'h2C;

   // ==========================================================
   // Configuration register bit positions
   localparam int CFG_PARALLEL   = 0;
   localparam int CFG_EXTRA_SAFE = 1;
   localparam int CFG_AUTOTUNE   = 2;
   localparam int CFG_REDUCED_HY = 3;
   localparam int CFG_INC_FBK    = 4;
   localparam int CFG_IR_SOURCE  = 5;
   localparam int CFG_ECONOMY    = 6;
   localparam int CFG_SERIES_REQ = 7;
   localparam int CFG_LOCKOUT    = 8;

   // ==========================================================
   // Reset values
   localparam logic [10:0] RST_EMF_SET     = 11'h3E8;
   localparam logic [10:0] RST_MAX_PRIMARY = 11'h3E8;
   localparam logic [10:0] RST_MAX_ECONOMY = 11'h1F4;
   localparam logic [10:0] RST_MIN_FIELD   = 11'h1F4;
   localparam logic [7:0]  RST_FBK_SCALE   = 8'hCC;
   localparam logic [7:0]  RST_IR_FACTOR   = 8'h00;

   // ==========================================================
   // Value ranges and scaling
   localparam logic [10:0] VAL_MAX        = 11'h3E8;
   localparam logic [10:0] FIRE_MIN       = 11'h105;
   localparam logic [7:0]  SCALE_MIN      = 8'hC9;
   localparam logic [7:0]  SCALE_MAX      = 8'hD8;
   localparam logic [7:0]  SCALE_LOW_TOP  = 8'hCC;
   localparam int          IR_SHIFT       = 11;
   // Hysteresis in tenths of a percent of full current (1000)
   localparam logic [10:0] HYST_NORMAL    = 11'h010;
   localparam logic [10:0] HYST_REDUCED   = 11'h002;
   // Feedback rescale 1/1.6 as 5/8
   localparam logic [3:0]  INC_FBK_NUM    = 4'h5;
   localparam int          INC_FBK_SHIFT  = 3;

   // Feedback and demand inputs sampled each supply cycle
   typedef struct packed {
      logic signed [11:0] arm_voltage;
      logic signed [11:0] speed_err_int;
      logic signed [11:0] current_demand;
      logic signed [11:0] arm_current;
      logic        [10:0] field_fbk_raw;
      logic               ripple_high;
   } fcc_meas_t;

   typedef enum logic [1:0] {
      BR_FORWARD,
      BR_WAIT,
      BR_MARGIN,
      BR_REVERSE
   } fcc_bridge_t;

endpackage : fcc_pkg

// ==== hdl/fcc_sat.sv ====
// Signed saturating clamp used by the IR, back-emf, voltage loop, demand and firing arithmetic.
// Assumes the limits satisfy lo <= hi.
module fcc_sat #(
   parameter int IW = 24,
   parameter int OW = 12
) (
   input  wire logic signed [IW-1:0] din,
   input  wire logic signed [OW-1:0] lo,
   input  wire logic signed [OW-1:0] hi,
   output logic      signed [OW-1:0] dout
);
   always_comb begin
      if (din < IW'(lo)) begin
         dout = lo;
      end else if (din > IW'(hi)) begin
         dout = hi;
      end else begin
         dout = din[OW-1:0];
      end
   end
endmodule : fcc_sat

// ==== hdl/fcc_field_ctrl.sv ====
// Field current controller: bridge changeover options, IR compensation,
// back-emf voltage loop, field current loop and feedback scaling.
// Assumes synchronous measurement inputs and a supply-cycle strobe.
// Overview of operation
// RQ1 - Parallel bit selects parallel twelve-pulse bridge firing mode.
// RQ2 - Integrator sets lockout bit and cross-wires partner lockout for 4Q.
// RQ3 - Extra-safe bit adds one supply cycle before bridge changeover.
// RQ4 - Autotune adjusts gains from ripple; integral gain never touched.
// RQ5 - Autotune frozen while voltage spill-over loop is active.
// RQ6 - Autotune inactive in series twelve-pulse mode.
// RQ7 - Changeover hysteresis 1.6% normally, 0.2% when reduced bit set.
// RQ8 - Increased feedback bit rescales armature current by 1/1.6.
// RQ9 - Field error is demand minus feedback; loop output is firing angle.
// RQ10 - Field demand is voltage loop output clamped between min and max.
// RQ11 - Voltage loop gives max demand below setpoint, regulates above.
// RQ12 - Two maximum field values; economy selects the lower one.
// RQ13 - Back-emf is armature voltage minus IR compensation output.
// RQ14 - Firing angle ranges 261 to 1000.
// RQ15 - IR output is source times factor over 2048, source selectable.
// RQ16 - Demand and feedback 0 to 1000; IR output plus or minus 1000.
// RQ17 - Back-emf setpoint 0 to 1000, default 1000.
// RQ18 - Maximum field current 1 defaults to 1000.
// RQ19 - Maximum field current 2 defaults to 500, used in economy.
// RQ20 - Minimum field current defaults to 500, floor on demand.
// RQ21 - Feedback scale code 201 to 216, default 204, jumper range checked.
// RQ22 - Installer ensures supply phase rotation L1, L2, L3.
// RQ23 - Series bit latched from the request bit while disabled; forced 0 if bridge 2 on.
// RQ24 - Economy timeout selects maximum field 2 automatically.
// RQ25 - Loop arithmetic saturates at range limits.
module fcc_field_ctrl
   import fcc_pkg::*;
#(
   parameter int GAIN_W = 8
) (
   input  wire logic              sys_clk,
   input  wire logic              reset,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              supply_tick,
   input  wire logic              drive_enabled,
   input  wire logic              bridge2_quadrant_on,
   input  wire logic              economy_request,
   input  wire logic              partner_lockout_input,
   input  wire logic              feedback_range_jumper,
   input  wire fcc_meas_t         meas,
   output logic                   bridge_state_output,
   output logic                   parallel_mode,
   output logic                   series_mode,
   output logic [10:0]            field_firing_angle,
   output logic [GAIN_W-1:0]      autotune_gain,
   output logic                   scale_fault
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [8:0]         cfg;
      logic               series;
      logic [7:0]         ir_factor;
      logic [10:0]        emf_set;
      logic [10:0]        max_primary;
      logic [10:0]        max_economy;
      logic [10:0]        min_field;
      logic [7:0]         fbk_scale;
      logic [10:0]        demand;
      logic [10:0]        fbk;
      logic [10:0]        fire;
      logic signed [11:0] ir_out;
      logic signed [11:0] vloop;
      logic [GAIN_W-1:0]  gain;
      fcc_bridge_t        bridge;
      logic [31:0]        rdata;
      logic               lock_s1;
      logic               lock_s2;
      logic               jmp_s1;
      logic               jmp_s2;
   } fcc_state_t;

   fcc_state_t st_ff;
   fcc_state_t nxt_st;

   // ==========================================================
   // Arithmetic with saturation
   logic signed [23:0] ir_raw;
   logic signed [11:0] ir_sat;
   logic signed [23:0] emf_raw;
   logic signed [11:0] emf_sat;
   logic signed [23:0] vl_raw;
   logic signed [11:0] vl_sat;
   logic signed [23:0] dm_raw;
   logic signed [11:0] dm_sat;
   logic signed [23:0] fr_raw;
   logic signed [11:0] fr_sat;
   logic signed [11:0] max_sel;
   logic signed [11:0] ir_src;
   logic signed [11:0] field_err;
   logic signed [11:0] arm_i;
   logic signed [11:0] hyst;
   logic               spill_active;
   logic               autotune_run;
   logic               wr_en;
   logic               rd_en;

   // RQ12 RQ24 economy selects max field 2
   assign max_sel = st_ff.cfg[CFG_ECONOMY] || economy_request ?
                    signed'({1'b0, st_ff.max_economy}) :
                    signed'({1'b0, st_ff.max_primary});

   // RQ15 IR source select
   assign ir_src = st_ff.cfg[CFG_IR_SOURCE] ? meas.current_demand : meas.speed_err_int;
   assign ir_raw = (24'(ir_src) * 24'(signed'({1'b0, st_ff.ir_factor}))) >>> IR_SHIFT;

   // RQ16 IR output range
   fcc_sat u_sat_ir (
      .din  (ir_raw),
      .lo   (-12'sh3E8),
      .hi   (12'sh3E8),
      .dout (ir_sat)
   );

   // RQ13 back-emf from armature voltage
   assign emf_raw = 24'(meas.arm_voltage) - 24'(st_ff.ir_out);
   fcc_sat u_sat_emf (
      .din  (emf_raw),
      .lo   (-12'sh3E8),
      .hi   (12'sh3E8),
      .dout (emf_sat)
   );

   // RQ11 integrating voltage loop, saturating at maximum field
   assign vl_raw = 24'(st_ff.vloop) - 24'((emf_sat - signed'({1'b0, st_ff.emf_set})) >>> 2);
   fcc_sat u_sat_vl (
      .din  (vl_raw),
      .lo   (12'sh000),
      .hi   (max_sel),
      .dout (vl_sat)
   );
   assign spill_active = (st_ff.vloop < max_sel);

   // RQ10 demand clamp between min and selected max
   assign dm_raw = 24'(vl_sat);
   fcc_sat u_sat_dm (
      .din  (dm_raw),
      .lo   ((st_ff.min_field < 11'(max_sel)) ? signed'({1'b0, st_ff.min_field}) : max_sel),
      .hi   (max_sel),
      .dout (dm_sat)
   );

   // RQ9 field error and firing loop, RQ14 angle limits
   assign field_err = signed'({1'b0, st_ff.demand}) - signed'({1'b0, st_ff.fbk});
   assign fr_raw = 24'(signed'({1'b0, st_ff.fire})) + 24'(field_err >>> 3);
   fcc_sat u_sat_fr (
      .din  (fr_raw),
      .lo   (signed'({1'b0, FIRE_MIN})),
      .hi   (signed'({1'b0, VAL_MAX})),
      .dout (fr_sat)
   );

   // RQ8 armature current rescale for raised burden
   assign arm_i = st_ff.cfg[CFG_INC_FBK] ?
                  12'((24'(meas.arm_current) * 24'(INC_FBK_NUM)) >>> INC_FBK_SHIFT) :
                  meas.arm_current;
   // RQ7 hysteresis choice
   assign hyst = signed'({1'b0, st_ff.cfg[CFG_REDUCED_HY] ? HYST_REDUCED : HYST_NORMAL});

   // RQ6 RQ5 autotune gating
   assign autotune_run = st_ff.cfg[CFG_AUTOTUNE] && !st_ff.series && !spill_active;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;

   // ==========================================================
   // Next state
   always_comb begin
      nxt_st = st_ff;
      nxt_st.lock_s1 = partner_lockout_input;
      nxt_st.lock_s2 = st_ff.lock_s1;
      nxt_st.jmp_s1 = feedback_range_jumper;
      nxt_st.jmp_s2 = st_ff.jmp_s1;

      // RQ23 series bit latched from the request bit in any cycle while the drive is disabled
      if (!drive_enabled && st_ff.cfg[CFG_SERIES_REQ] && !st_ff.series) begin
         nxt_st.series = !bridge2_quadrant_on;
         if (bridge2_quadrant_on) begin
            nxt_st.cfg[CFG_SERIES_REQ] = 1'b0;
         end
      end

      if (supply_tick) begin
         nxt_st.ir_out = ir_sat;
         nxt_st.vloop = vl_sat;
         nxt_st.demand = 11'(dm_sat);
         nxt_st.fire = 11'(fr_sat);
         // RQ21 feedback scaling by code
         nxt_st.fbk = 11'((24'(meas.field_fbk_raw) *
                          24'(st_ff.fbk_scale - SCALE_MIN + 8'h01)) >>> 4);
         if (nxt_st.fbk > VAL_MAX) begin
            nxt_st.fbk = VAL_MAX;
         end
         // RQ4 autotune steers proportional gain only
         if (autotune_run) begin
            if (meas.ripple_high && st_ff.gain != '0) begin
               nxt_st.gain = st_ff.gain - 1'b1;
            end else if (!meas.ripple_high && st_ff.gain != '1) begin
               nxt_st.gain = st_ff.gain + 1'b1;
            end
         end
         // RQ3 RQ7 bridge changeover with hysteresis and margin
         case (st_ff.bridge)
            BR_FORWARD: begin
               if (arm_i < -hyst && !(st_ff.cfg[CFG_LOCKOUT] && st_ff.lock_s2)) begin
                  nxt_st.bridge = BR_WAIT;
               end
            end
            BR_WAIT: begin
               nxt_st.bridge = st_ff.cfg[CFG_EXTRA_SAFE] ? BR_MARGIN : BR_REVERSE;
            end
            BR_MARGIN: begin
               nxt_st.bridge = BR_REVERSE;
            end
            BR_REVERSE: begin
               if (arm_i > hyst && !(st_ff.cfg[CFG_LOCKOUT] && st_ff.lock_s2)) begin
                  nxt_st.bridge = BR_FORWARD;
               end
            end
            default: begin
               nxt_st.bridge = BR_FORWARD;
            end
         endcase
      end

      // RQ25 setpoint, limit and scale register writes saturate; config and IR factor take the low bits
      if (wr_en) begin
         if (paddr == OFS_CONFIG) begin
            nxt_st.cfg = pwdata[8:0];
         end else if (paddr == OFS_IR_FACTOR) begin
            nxt_st.ir_factor = pwdata[7:0];
         end else if (paddr == OFS_EMF_SET) begin
            // RQ17 setpoint range
            nxt_st.emf_set = (pwdata > 32'(VAL_MAX)) ? VAL_MAX : pwdata[10:0];
         end else if (paddr == OFS_MAX_PRIMARY) begin
            nxt_st.max_primary = (pwdata > 32'(VAL_MAX)) ? VAL_MAX : pwdata[10:0];
         end else if (paddr == OFS_MAX_ECONOMY) begin
            nxt_st.max_economy = (pwdata > 32'(VAL_MAX)) ? VAL_MAX : pwdata[10:0];
         end else if (paddr == OFS_MIN_FIELD) begin
            nxt_st.min_field = (pwdata > 32'(VAL_MAX)) ? VAL_MAX : pwdata[10:0];
         end else if (paddr == OFS_FBK_SCALE) begin
            // RQ21 code range limits
            if (pwdata < 32'(SCALE_MIN)) begin
               nxt_st.fbk_scale = SCALE_MIN;
            end else if (pwdata > 32'(SCALE_MAX)) begin
               nxt_st.fbk_scale = SCALE_MAX;
            end else begin
               nxt_st.fbk_scale = pwdata[7:0];
            end
         end
      end

      // Read data latched in the setup cycle
      if (rd_en) begin
         nxt_st.rdata = '0;
         if (paddr == OFS_CONFIG) begin
            nxt_st.rdata = 32'(st_ff.cfg);
         end else if (paddr == OFS_STATUS) begin
            nxt_st.rdata = {24'h000000, st_ff.gain[0], scale_fault, spill_active,
                            autotune_run, st_ff.series, 1'b0, st_ff.bridge};
         end else if (paddr == OFS_FIELD_DEMAND) begin
            nxt_st.rdata = 32'(st_ff.demand);
         end else if (paddr == OFS_FIELD_FBK) begin
            nxt_st.rdata = 32'(st_ff.fbk);
         end else if (paddr == OFS_FIRING) begin
            nxt_st.rdata = 32'(st_ff.fire);
         end else if (paddr == OFS_IR_OUT) begin
            nxt_st.rdata = 32'(signed'(st_ff.ir_out));
         end else if (paddr == OFS_IR_FACTOR) begin
            nxt_st.rdata = 32'(st_ff.ir_factor);
         end else if (paddr == OFS_EMF_SET) begin
            nxt_st.rdata = 32'(st_ff.emf_set);
         end else if (paddr == OFS_MAX_PRIMARY) begin
            nxt_st.rdata = 32'(st_ff.max_primary);
         end else if (paddr == OFS_MAX_ECONOMY) begin
            nxt_st.rdata = 32'(st_ff.max_economy);
         end else if (paddr == OFS_MIN_FIELD) begin
            nxt_st.rdata = 32'(st_ff.min_field);
         end else if (paddr == OFS_FBK_SCALE) begin
            nxt_st.rdata = 32'(st_ff.fbk_scale);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_ff             <= '0;
         // RQ18 RQ19 RQ20 register defaults
         st_ff.emf_set     <= RST_EMF_SET;
         st_ff.max_primary <= RST_MAX_PRIMARY;
         st_ff.max_economy <= RST_MAX_ECONOMY;
         st_ff.min_field   <= RST_MIN_FIELD;
         st_ff.fbk_scale   <= RST_FBK_SCALE;
         st_ff.ir_factor   <= RST_IR_FACTOR;
         st_ff.fire        <= FIRE_MIN;
         st_ff.bridge      <= BR_FORWARD;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================
   // Outputs
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign prdata  = st_ff.rdata;
   // RQ1 parallel mode output
   assign parallel_mode       = st_ff.cfg[CFG_PARALLEL];
   assign series_mode         = st_ff.series;
   assign bridge_state_output = (st_ff.bridge != BR_FORWARD);
   assign field_firing_angle  = st_ff.fire;
   assign autotune_gain       = st_ff.gain;
   // RQ21 jumper range check
   assign scale_fault = (st_ff.fbk_scale > SCALE_LOW_TOP) != st_ff.jmp_s2;

   // ==========================================================
   // Checks
   a_fire_range: assert property (@(posedge sys_clk) disable iff (reset) // RQ14
      st_ff.fire >= FIRE_MIN && st_ff.fire <= VAL_MAX)
      else $error("firing angle out of range");
   a_demand_ceiling: assert property (@(posedge sys_clk) disable iff (reset) // RQ10
      supply_tick |=> st_ff.demand <= 11'($past(max_sel)))
      else $error("demand above selected maximum");
   a_ir_range: assert property (@(posedge sys_clk) disable iff (reset) // RQ16
      st_ff.ir_out <= 12'sh3E8 && st_ff.ir_out >= -12'sh3E8)
      else $error("IR output out of range");
   a_autotune_series: assert property (@(posedge sys_clk) disable iff (reset) // RQ6
      st_ff.series |=> $stable(st_ff.gain))
      else $error("autotune ran in series mode");
   a_autotune_spill: assert property (@(posedge sys_clk) disable iff (reset) // RQ5
      spill_active && !wr_en |=> $stable(st_ff.gain))
      else $error("autotune ran during spill-over");
   a_extra_margin: assert property (@(posedge sys_clk) disable iff (reset) // RQ3
      st_ff.bridge == BR_WAIT && supply_tick && st_ff.cfg[CFG_EXTRA_SAFE]
      |=> st_ff.bridge == BR_MARGIN)
      else $error("margin cycle skipped");
   a_series_block: assert property (@(posedge sys_clk) disable iff (reset) // RQ23
      !drive_enabled && bridge2_quadrant_on && !st_ff.series |=> !st_ff.series)
      else $error("series enabled with bridge 2");
   a_scale_range: assert property (@(posedge sys_clk) disable iff (reset) // RQ21
      st_ff.fbk_scale >= SCALE_MIN && st_ff.fbk_scale <= SCALE_MAX)
      else $error("scale code out of range");

endmodule : fcc_field_ctrl

// ==== testbench/fcc_far_model.sv ====
// Far-side model: supply-cycle strobe, armature and field feedback, partner drive lockout.
// Assumes one clock; bench supplies the armature-side measurements as levels.
module fcc_far_model
   import fcc_pkg::*;
#(
   parameter int TICK_DIV = 8
) (
   input  wire logic               sys_clk,
   input  wire logic               reset,
   input  wire logic signed [11:0] arm_v,
   input  wire logic signed [11:0] spd_int,
   input  wire logic signed [11:0] cur_dem,
   input  wire logic [10:0]        firing,
   input  wire logic               bridge_state,
   output logic                    supply_tick,
   output logic                    partner_lock,
   output fcc_meas_t               meas
);
   timeunit 1ns;
   timeprecision 1ps;
   int          div_cnt;
   logic [10:0] fbk_ff;
   logic        ripple_ff;

   // ==========================================================
   // Supply cycle pacing and field lag
   // one tick every TICK_DIV clocks stands for a supply cycle; phases not modelled
   always @(posedge sys_clk) begin
      if (reset) begin
         div_cnt     <= 0;
         supply_tick <= 1'b0;
         fbk_ff      <= 11'h000;
         ripple_ff   <= 1'b0;
      end else begin
         div_cnt     <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
         supply_tick <= (div_cnt == TICK_DIV - 1);
         if (supply_tick) begin
            fbk_ff    <= (firing > FIRE_MIN) ? firing - FIRE_MIN : 11'h000;
            ripple_ff <= ~ripple_ff;
         end
      end
   end

   always @(posedge sys_clk) begin
      partner_lock <= reset ? 1'b0 : bridge_state;
   end

   always_comb begin
      meas.arm_voltage    = arm_v;
      meas.speed_err_int  = spd_int;
      meas.current_demand = cur_dem;
      meas.arm_current    = cur_dem;
      meas.field_fbk_raw  = fbk_ff;
      meas.ripple_high    = ripple_ff;
   end
endmodule : fcc_far_model

// ==== testbench/field_current_controller_test.sv ====
// Self-checking bench for the field current controller over APB.
// Assumes the far-side model paces the loops and answers with field feedback.
module field_current_controller_test
   import fcc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, supply_tick, drv_en = 1'b0, br2_on = 1'b0, econ_req = 1'b0;
   logic part_lock, jumper = 1'b0, br_state, par_mode, ser_mode, scale_fault;
   logic signed [11:0] arm_v = 12'sh064, spd_int = 12'sh000, cur_dem = 12'sh000;
   logic [10:0] firing;
   logic [7:0]  gain;
   fcc_meas_t   meas;
   int miscompares = 0, checks = 0;

   always #20 sys_clk = ~sys_clk;

   fcc_field_ctrl dut_u (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .supply_tick(supply_tick), .drive_enabled(drv_en),
      .bridge2_quadrant_on(br2_on), .economy_request(econ_req),
      .partner_lockout_input(part_lock), .feedback_range_jumper(jumper), .meas(meas),
      .bridge_state_output(br_state), .parallel_mode(par_mode), .series_mode(ser_mode),
      .field_firing_angle(firing), .autotune_gain(gain), .scale_fault(scale_fault));

   fcc_far_model far_u (.sys_clk(sys_clk), .reset(reset), .arm_v(arm_v), .spd_int(spd_int),
      .cur_dem(cur_dem), .firing(firing), .bridge_state(br_state), .supply_tick(supply_tick),
      .partner_lock(part_lock), .meas(meas));

   // ==========================================================
   // Shared tasks
   task automatic complete_run;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : complete_run

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         check("pready wait", 32'h0, 32'h1);
         complete_run();
      end
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(what, rd, exp);
   endtask : rd_chk

   task automatic wait_ticks(input int k);
      int n;
      int lim;
      lim = k * 20;
      for (n = 0; n < lim && k > 0; n++) begin
         @(posedge sys_clk);
         if (supply_tick === 1'b1) k--;
      end
      if (k > 0) begin
         check("tick wait", 32'h0, 32'h1);
         complete_run();
      end
   endtask : wait_ticks

   // ==========================================================
   // Scenarios
   task automatic t_reset_vals;
      logic [7:0]  ofs [7] = '{OFS_CONFIG, OFS_IR_FACTOR, OFS_EMF_SET, OFS_MAX_PRIMARY,
                               OFS_MAX_ECONOMY, OFS_MIN_FIELD, OFS_FBK_SCALE};
      logic [31:0] exp [7] = '{32'h0, 32'h0, 32'h3E8, 32'h3E8, 32'h1F4, 32'h1F4, 32'hCC};
      check("firing at reset", {21'h0, firing}, {21'h0, FIRE_MIN});
      for (int i = 0; i < 7; i++) rd_chk("reset value", ofs[i], exp[i]);
   endtask : t_reset_vals

   task automatic t_reg_limits;
      apb(1'b1, OFS_EMF_SET, 32'h7FF);
      rd_chk("setpoint clamp", OFS_EMF_SET, 32'h3E8);
      apb(1'b1, OFS_FBK_SCALE, 32'hFA);
      rd_chk("scale clamp high", OFS_FBK_SCALE, 32'hD8);
      apb(1'b1, OFS_FBK_SCALE, 32'h10);
      rd_chk("scale clamp low", OFS_FBK_SCALE, 32'hC9);
      apb(1'b1, 8'h40, 32'h5A5);
      rd_chk("unmapped read", 8'h40, 32'h0);
      check("no slave error", {31'h0, pslverr}, 32'h0);
   endtask : t_reg_limits

   task automatic t_scale_fault;
      apb(1'b1, OFS_FBK_SCALE, 32'hCD);
      jumper <= 1'b0;
      repeat (4) @(posedge sys_clk);
      check("high code low jumper", {31'h0, scale_fault}, 32'h1);
      jumper <= 1'b1;
      repeat (4) @(posedge sys_clk);
      check("high code high jumper", {31'h0, scale_fault}, 32'h0);
      apb(1'b1, OFS_FBK_SCALE, 32'hCC);
      repeat (2) @(posedge sys_clk);
      check("low code high jumper", {31'h0, scale_fault}, 32'h1);
      jumper <= 1'b0;
   endtask : t_scale_fault

   task automatic t_ir_comp;
      apb(1'b1, OFS_IR_FACTOR, 32'h80);
      spd_int <= 12'sh320;
      cur_dem <= -12'sh190;
      wait_ticks(4);
      rd_chk("ir from speed integral", OFS_IR_OUT, 32'h32);
      apb(1'b1, OFS_CONFIG, 32'h1 << CFG_IR_SOURCE);
      wait_ticks(4);
      apb(1'b0, OFS_IR_OUT, 32'h0);
      check("ir from current demand", {21'h0, rd[10:0]}, 32'h7E7);
      apb(1'b1, OFS_CONFIG, 32'h0);
      apb(1'b1, OFS_IR_FACTOR, 32'h0);
   endtask : t_ir_comp

   task automatic t_field_loop;
      arm_v <= 12'sh064;
      wait_ticks(200);
      rd_chk("demand at primary max", OFS_FIELD_DEMAND, 32'h3E8);
      check("firing in range", {31'h0, firing >= FIRE_MIN && firing <= VAL_MAX}, 32'h1);
      econ_req <= 1'b1;
      wait_ticks(200);
      rd_chk("demand at economy max", OFS_FIELD_DEMAND, 32'h1F4);
      apb(1'b1, OFS_CONFIG, 32'h1 << CFG_ECONOMY);
      econ_req <= 1'b0;
      wait_ticks(4);
      rd_chk("economy select bit", OFS_FIELD_DEMAND, 32'h1F4);
      apb(1'b1, OFS_CONFIG, 32'h0);
      apb(1'b1, OFS_EMF_SET, 32'hC8);
      arm_v <= 12'sh320;
      wait_ticks(300);
      rd_chk("spill demand at floor", OFS_FIELD_DEMAND, 32'h1F4);
      apb(1'b0, OFS_FIELD_FBK, 32'h0);
      check("feedback range", {31'h0, rd <= 32'h3E8}, 32'h1);
      check("firing in range", {31'h0, firing >= FIRE_MIN && firing <= VAL_MAX}, 32'h1);
      apb(1'b1, OFS_EMF_SET, 32'h3E8);
      arm_v <= 12'sh064;
      wait_ticks(200);
   endtask : t_field_loop

   task automatic t_modes;
      logic [7:0] g;
      apb(1'b1, OFS_CONFIG, 32'h1 << CFG_PARALLEL);
      repeat (2) @(posedge sys_clk);
      check("parallel mode", {31'h0, par_mode}, 32'h1);
      apb(1'b1, OFS_CONFIG, 32'h1 << CFG_AUTOTUNE);
      wait_ticks(2);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("autotune running", {31'h0, rd[4]}, 32'h1);
      check("parallel mode off", {31'h0, par_mode}, 32'h0);
      br2_on <= 1'b1;
      apb(1'b1, OFS_CONFIG, (32'h1 << CFG_AUTOTUNE) | (32'h1 << CFG_SERIES_REQ));
      wait_ticks(2);
      check("series blocked by bridge 2", {31'h0, ser_mode}, 32'h0);
      br2_on <= 1'b0;
      apb(1'b1, OFS_CONFIG, (32'h1 << CFG_AUTOTUNE) | (32'h1 << CFG_SERIES_REQ));
      wait_ticks(2);
      check("series latched", {31'h0, ser_mode}, 32'h1);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("autotune off in series", {31'h0, rd[4]}, 32'h0);
      g = gain;
      wait_ticks(2);
      check("gain frozen in series", {24'h0, gain}, {24'h0, g});
   endtask : t_modes

   task automatic t_bridge;
      apb(1'b1, OFS_CONFIG, 32'h0);
      cur_dem <= 12'sh00C;
      wait_ticks(3);
      check("wide hysteresis", {31'h0, br_state}, 32'h1);
      apb(1'b1, OFS_CONFIG, 32'h1A);
      wait_ticks(1);
      cur_dem <= -12'sh003;
      wait_ticks(2);
      check("narrow hysteresis", {31'h0, br_state}, 32'h0);
      apb(1'b1, OFS_CONFIG, 32'h0A);
      wait_ticks(2);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("margin cycle", {30'h0, rd[1:0]}, {30'h0, BR_MARGIN});
   endtask : t_bridge

   // ==========================================================
   // Main sequence
   initial begin
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      t_reset_vals();
      t_reg_limits();
      t_scale_fault();
      t_ir_comp();
      t_field_loop();
      t_modes();
      t_bridge();
      complete_run();
   end
endmodule : field_current_controller_test
